// [hdl/crss_lane_if.sv]
// Access signals between the steering logic and one lane register set.
// Assumes both ends run on the same clock.
interface crss_lane_if;
	import crss_pkg::*;
	logic       wr;
	logic       rd;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	logic [7:0] ctrl;

	modport lane (input wr, input rd, input addr, input wdata,
		output rdata, output ctrl);
	modport steer (output wr, output rd, output addr, output wdata,
		input rdata, input ctrl);
endinterface

// [hdl/crss_lane_regs.sv]
// One lane register set: soft reset controls and sticky loss flags.
// Assumes lock and signal inputs are already synchronised to clk.
module crss_lane_regs
	import crss_pkg::*;
(
	input wire logic   clk,
	input wire logic   rst_n,
	input wire logic   lock_sync,
	input wire logic   signal_sync,
	crss_lane_if.lane  port_if
);

	logic [7:0] ctrl;
	logic [2:0] flag_spare;
	logic       lock_lost_flag;
	logic       signal_lost_flag;
	logic       lock_prev;
	logic       signal_prev;

	// ****************************************************************
	// Decode
	// ****************************************************************

	// A restore request lasts one cycle because it clears itself.
	wire restore  = ctrl[CTRL_REGS_BIT];
	wire wr_ctrl  = port_if.wr && (port_if.addr == LANE_CTRL_ADDR);
	wire wr_flags = port_if.wr && (port_if.addr == LANE_FLAGS_ADDR);
	wire rd_flags = port_if.rd && (port_if.addr == LANE_FLAGS_ADDR);
	// Falling edges mean the level was present the cycle before.
	wire lock_drop   = lock_prev && !lock_sync;
	wire signal_drop = signal_prev && !signal_sync;

	wire [7:0] flags_value = {flag_spare, lock_lost_flag, 3'h0,
		signal_lost_flag};

	// Read mux; unmapped lane addresses read as zero.
	assign port_if.rdata = (port_if.addr == LANE_CTRL_ADDR) ? ctrl :
		(port_if.addr == LANE_FLAGS_ADDR) ? flags_value : 8'h00;
	assign port_if.ctrl = ctrl;

	// ****************************************************************
	// Registers
	// ****************************************************************

	// Control register; bit 2 puts the whole set back to defaults.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl       <= CTRL_RESET;
			flag_spare <= FLAG_SPARE_RESET;
		end else if (restore) begin
			ctrl       <= CTRL_RESET;
			flag_spare <= FLAG_SPARE_RESET;
		end else begin
			if (wr_ctrl)
				ctrl <= port_if.wdata;
			if (wr_flags)
				flag_spare <= port_if.wdata[7:5];
		end
	end

	// Sticky flags; a new event wins over a clear in the same cycle.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			lock_lost_flag   <= 1'b0;
			signal_lost_flag <= 1'b0;
			lock_prev        <= 1'b0;
			signal_prev      <= 1'b0;
		end else begin
			lock_prev   <= lock_sync;
			signal_prev <= signal_sync;
			if (lock_drop)
				lock_lost_flag <= 1'b1;
			else if (rd_flags || restore)
				lock_lost_flag <= 1'b0;
			if (signal_drop)
				signal_lost_flag <= 1'b1;
			else if (restore)
				signal_lost_flag <= 1'b0;
		end
	end

endmodule

// [hdl/crss_pkg.sv]
// Constants, field layout and access kinds for the lane register steering.
// Assumes a single 50 MHz management clock and byte-wide register access.
package crss_pkg;

	// ****************************************************************
	// Sizes and addresses
	// ****************************************************************
	localparam int       NUM_LANES        = 4;
	localparam logic [7:0] SELECT_ADDR    = 8'hff;
	localparam logic [7:0] LANE_CTRL_ADDR = 8'h00;
	localparam logic [7:0] LANE_FLAGS_ADDR = 8'h01;

	// ****************************************************************
	// Field positions and values after reset
	// ****************************************************************
	localparam int         SEL_BROADCAST_BIT = 3;
	localparam int         SEL_ENABLE_BIT    = 2;
	localparam int         SEL_INDEX_LSB     = 0;
	localparam logic [3:0] SELECT_RESET      = 4'h0;
	localparam logic [7:0] SELECT_READ_VALUE = 8'h00;

	localparam int         CTRL_CORE_BIT   = 3;
	localparam int         CTRL_REGS_BIT   = 2;
	localparam int         CTRL_REFCLK_BIT = 1;
	localparam int         CTRL_VCO_BIT    = 0;
	localparam logic [7:0] CTRL_RESET      = 8'h00;

	localparam int         FLAG_LOCK_LOST_BIT   = 4;
	localparam int         FLAG_SIGNAL_LOST_BIT = 0;
	localparam logic [2:0] FLAG_SPARE_RESET     = 3'h0;

	// Where a staged access is steered.
	typedef enum logic [1:0] {
		CRSS_TO_SHARED = 2'b00,
		CRSS_TO_LANES  = 2'b01,
		CRSS_TO_SELECT = 2'b10
	} crss_target_type;

endpackage

// [hdl/crss_steer.sv]
// Register steering between the shared set and four lane sets.
// Holds the select register, the access staging and the read answer.
// Assumes a framing front end delivers one-cycle read and write strobes
// and that the shared set answers combinationally in the staged cycle.
// Assumes lane status pins may change at any time, on any clock.
module crss_steer
	import crss_pkg::*;
(
	// Clock, reset and host register port.
	input  wire logic       sys_clk,
	input  wire logic       reset_n,
	input  wire logic [7:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output logic      [7:0] reg_rdata,
	output logic            reg_rvalid,
	// Shared register set standing behind the steering.
	output logic      [7:0] shared_addr,
	output logic      [7:0] shared_wdata,
	output logic            shared_wr,
	output logic            shared_rd,
	input  wire logic [7:0] shared_rdata,
	// Lane status pins and lane reset controls.
	input  wire logic [3:0] lock_in,
	input  wire logic [3:0] signal_in,
	output logic      [3:0] lane_core_reset,
	output logic      [3:0] refclk_domain_reset,
	output logic      [3:0] vco_divider_domain_reset
);

	// ****************************************************************
	// Reset release and pin synchronisers
	// ****************************************************************

	logic [1:0] rst_pipe;
	logic       rst_n;
	logic [3:0] lock_meta;
	logic [3:0] lock_sync;
	logic [3:0] signal_meta;
	logic [3:0] signal_sync;

	// Reset asserts at once and releases two edges later.
	// Releasing through flops lets every flop behind the pipe leave reset
	// on the same edge, so no lane set starts ahead of the steering.
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n)
			rst_pipe <= 2'h0;
		else
			rst_pipe <= {rst_pipe[0], 1'b1};
	end
	assign rst_n = rst_pipe[1];

	// Lane status pins come from analog blocks on other clocks.
	// Two flops trade two cycles of latency for a settled level; a
	// loss is therefore seen about three edges after the pin drops,
	// which is far quicker than any host can poll the flags.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			lock_meta   <= 4'h0;
			lock_sync   <= 4'h0;
			signal_meta <= 4'h0;
			signal_sync <= 4'h0;
		end else begin
			lock_meta   <= lock_in;
			lock_sync   <= lock_meta;
			signal_meta <= signal_in;
			signal_sync <= signal_meta;
		end
	end

	// ****************************************************************
	// Select register and request decode
	// ****************************************************************

	// The select register keeps only the four bits that decode.
	logic [3:0] select;
	logic       broadcast_write_enable;
	logic       lane_set_access_enable;
	logic [1:0] lane_index;

	// The select fields are named wires so the decode below reads
	// like the table of select values.
	assign broadcast_write_enable = select[SEL_BROADCAST_BIT];
	assign lane_set_access_enable = select[SEL_ENABLE_BIT];
	assign lane_index             = select[SEL_INDEX_LSB +: 2];

	// Address 0xff never reaches a lane set, whatever the selection.
	// Testing the address before the enable bit makes sure a select
	// write with lanes enabled still lands in the select register.
	wire hit_select = (reg_addr == SELECT_ADDR);
	wire hit_lanes  = lane_set_access_enable && !hit_select;
	wire crss_target_type next_target = hit_select ? CRSS_TO_SELECT :
		hit_lanes ? CRSS_TO_LANES : CRSS_TO_SHARED;
	// Broadcast widens writes only; reads stay on one lane.
	wire [3:0] next_wr_mask = broadcast_write_enable ? 4'hf :
		(4'h1 << lane_index);

	// The selection only changes on a write to 0xff, so it persists.
	// Upper bits are dropped; the host is expected to write them as zero.
	// With the enable bit clear, the index and broadcast bits are kept
	// but have no effect until the enable bit is set again.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n)
			select <= SELECT_RESET;
		else if (reg_wr && hit_select)
			select <= reg_wdata[3:0];
	end

	// ****************************************************************
	// Staged access
	// ****************************************************************

	crss_target_type stage_target;
	logic            stage_wr;
	logic            stage_rd;
	logic      [7:0] stage_addr;
	logic      [7:0] stage_wdata;
	logic      [3:0] stage_wr_mask;
	logic      [1:0] stage_rd_lane;

	// The target is fixed at request time so a later select write
	// cannot redirect an access already in flight.
	// Staging costs one cycle on every access, but both register sets
	// then see a registered strobe and address, which keeps the decode
	// out of the path from the host's strobes.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			stage_target  <= CRSS_TO_SHARED;
			stage_wr      <= 1'b0;
			stage_rd      <= 1'b0;
			stage_addr    <= 8'h00;
			stage_wdata   <= 8'h00;
			stage_wr_mask <= 4'h0;
			stage_rd_lane <= 2'h0;
			shared_wr     <= 1'b0;
			shared_rd     <= 1'b0;
		end else begin
			stage_target  <= next_target;
			stage_wr      <= reg_wr;
			stage_rd      <= reg_rd;
			stage_addr    <= reg_addr;
			stage_wdata   <= reg_wdata;
			stage_wr_mask <= next_wr_mask;
			stage_rd_lane <= lane_index;
			shared_wr     <= reg_wr && (next_target == CRSS_TO_SHARED);
			shared_rd     <= reg_rd && (next_target == CRSS_TO_SHARED);
		end
	end
	// The shared set sees the staged address and data straight from flops.
	assign shared_addr  = stage_addr;
	assign shared_wdata = stage_wdata;

	// ****************************************************************
	// Lane register sets
	// ****************************************************************

	logic [7:0] lane_rdata [NUM_LANES];

	// Strobes toward the lane sets, qualified by the staged target.
	wire        stage_lanes    = (stage_target == CRSS_TO_LANES);
	wire        lane_wr_strobe = stage_wr && stage_lanes;
	wire        lane_rd_strobe = stage_rd && stage_lanes;

	// One complete, independent set per lane.
	// Writes follow the mask fixed at request time, so a broadcast
	// lands in every set on the same edge. Reads go to one lane only,
	// so a broadcast selection cannot clear the loss flags of the
	// lanes that were not read.
	generate
		for (genvar i = 0; i < NUM_LANES; i++) begin : g_lane
			crss_lane_if lane_if ();
			assign lane_if.wr    = lane_wr_strobe &&
				stage_wr_mask[i];
			assign lane_if.rd    = lane_rd_strobe &&
				(stage_rd_lane == 2'(i));
			assign lane_if.addr  = stage_addr;
			assign lane_if.wdata = stage_wdata;
			assign lane_rdata[i] = lane_if.rdata;
			// Reset controls leave straight from each lane's control
			// flops, so the lane blocks never see a decode glitch.
			assign lane_core_reset[i]          = lane_if.ctrl[CTRL_CORE_BIT];
			assign refclk_domain_reset[i]      = lane_if.ctrl[CTRL_REFCLK_BIT];
			assign vco_divider_domain_reset[i] = lane_if.ctrl[CTRL_VCO_BIT];
			crss_lane_regs u_lane (
				.clk         (sys_clk),
				.rst_n       (rst_n),
				.lock_sync   (lock_sync[i]),
				.signal_sync (signal_sync[i]),
				.port_if     (lane_if.lane)
			);
		end
	endgenerate

	// ****************************************************************
	// Read answer
	// ****************************************************************

	// Sources of the answer, chosen by the target fixed at request
	// time. Lane data is taken in the staged cycle, so a flag that
	// clears on this read is returned as it stood before the clear.
	wire       read_select    = (stage_target == CRSS_TO_SELECT);
	wire [7:0] lane_read_word = lane_rdata[stage_rd_lane];

	// The select register has no readback path; a fixed value is
	// returned so the host never sees a floating byte.
	wire [7:0] read_mux = read_select ?
		SELECT_READ_VALUE :
		stage_lanes ? lane_read_word :
		shared_rdata;

	// Every read answers two edges after its strobe.
	// The data register only moves with an answer, so a host that
	// samples it a few cycles late still sees the byte it asked for.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata  <= 8'h00;
			reg_rvalid <= 1'b0;
		end else begin
			reg_rvalid <= stage_rd;
			if (stage_rd)
				reg_rdata <= read_mux;
		end
	end

endmodule

// [testbench/crss_shared_model.sv]
// Shared register set model standing behind the steering block.
// Answers reads combinationally in the cycle the read strobe is high.
module crss_shared_model (
	input wire logic       sys_clk,
	input wire logic [7:0] shared_addr,
	input wire logic [7:0] shared_wdata,
	input wire logic       shared_wr,
	input wire logic       shared_rd,
	output logic     [7:0] shared_rdata
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] mem [256];
	// Outside a read the bus shows the inverse, so a late sample shows up.
	assign shared_rdata = shared_rd ? mem[shared_addr] : ~mem[shared_addr];
	// Storage starts cleared and takes each staged write.
	initial foreach (mem[i]) mem[i] = 8'h00;
	always @(posedge sys_clk)
		if (shared_wr)
			mem[shared_addr] <= shared_wdata;
endmodule

// [testbench/crss_steer_checker.sv]
// Port checker for the lane register steering block.
// Bound to every crss_steer; sees only its top-level ports.
module crss_steer_checker
	import crss_pkg::*;
(
	input wire logic       sys_clk,
	input wire logic       reset_n,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic       reg_wr,
	input wire logic       reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic       reg_rvalid,
	input wire logic [7:0] shared_addr,
	input wire logic [7:0] shared_wdata,
	input wire logic       shared_wr,
	input wire logic       shared_rd,
	input wire logic [3:0] lane_core_reset,
	input wire logic [3:0] refclk_domain_reset,
	input wire logic [3:0] vco_divider_domain_reset
);
	// ****
	// Timing of the register port
	// ****
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	// A read is answered two edges after it is taken.
	sequence read_taken;
		reg_rd;
	endsequence
	sequence read_answer;
		##2 reg_rvalid;
	endsequence
	rvalid_delay_a: assert property (read_taken |-> read_answer)
		else $error("read answer late or missing");
	rvalid_cause_a: assert property (reg_rvalid |-> $past(reg_rd, 2))
		else $error("read answer without a read");
	rdata_hold_a: assert property (!reg_rvalid |-> $stable(reg_rdata))
		else $error("read data moved without an answer");
	shwr_cause_a: assert property (shared_wr |-> $past(reg_wr)
		&& shared_addr == $past(reg_addr) && shared_wdata == $past(reg_wdata))
		else $error("shared write not caused by host write");
	shrd_cause_a: assert property (shared_rd |-> $past(reg_rd)
		&& shared_addr == $past(reg_addr))
		else $error("shared read not caused by host read");
	select_no_shared_a: assert property (reg_wr && reg_addr == SELECT_ADDR
		|=> !shared_wr)
		else $error("select write leaked to shared set");
	select_read_zero_a: assert property (reg_rd && reg_addr == SELECT_ADDR
		|-> ##2 reg_rdata == SELECT_READ_VALUE)
		else $error("select readback not zero");
	ctrl_hold_a: assert property ($changed({lane_core_reset,
		refclk_domain_reset, vco_divider_domain_reset})
		|-> $past(reg_wr) || $past(reg_wr, 2) || $past(reg_wr, 3))
		else $error("lane reset outputs moved without a write");
endmodule

bind crss_steer crss_steer_checker chk_i (.sys_clk, .reset_n, .reg_addr,
	.reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .reg_rvalid, .shared_addr,
	.shared_wdata, .shared_wr, .shared_rd, .lane_core_reset,
	.refclk_domain_reset, .vco_divider_domain_reset);

// [testbench/crss_steer_tb_top.sv]
// Self-checking bench for the lane register steering block.
// Drives inputs at falling edges; shared set is the partner model.
module crss_steer_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic sys_clk = 0, reset_n = 0, reg_wr = 0, reg_rd = 0;
	logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata;
	logic [7:0] shared_addr, shared_wdata, shared_rdata;
	logic reg_rvalid, shared_wr, shared_rd;
	logic [3:0] lock_in = 4'hf, signal_in = 4'hf;
	logic [3:0] lane_core_reset, refclk_domain_reset;
	logic [3:0] vco_divider_domain_reset;
	int miscompares = 0, check_count = 0;
	always #10 sys_clk = ~sys_clk;
	crss_steer dut (.sys_clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr,
		.reg_rd, .reg_rdata, .reg_rvalid, .shared_addr, .shared_wdata,
		.shared_wr, .shared_rd, .shared_rdata, .lock_in, .signal_in,
		.lane_core_reset, .refclk_domain_reset, .vco_divider_domain_reset);
	crss_shared_model sh (.sys_clk, .shared_addr, .shared_wdata,
		.shared_wr, .shared_rd, .shared_rdata);
	// ****
	// Checking and access tasks
	// ****
	task automatic chk(input string n, input logic [7:0] s, e);
		check_count++;
		if (s !== e) begin
			miscompares++;
			$display("mismatch %s exp %h seen %h", n, e, s);
		end
	endtask
	task automatic tally_and_finish;
		if (miscompares == 0 && check_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// One-cycle write strobe, then room for the write to land.
	task automatic wr(input logic [7:0] a, d);
		@(negedge sys_clk);
		reg_wr = 1;
		reg_addr = a;
		reg_wdata = d;
		@(negedge sys_clk);
		reg_wr = 0;
		repeat (3) @(negedge sys_clk);
	endtask
	// A read waits for its answer, but never longer than eight cycles.
	task automatic rd(input logic [7:0] a, e);
		int n;
		@(negedge sys_clk);
		reg_rd = 1;
		reg_addr = a;
		@(negedge sys_clk);
		reg_rd = 0;
		n = 0;
		while (reg_rvalid !== 1'b1 && n < 8) begin
			@(negedge sys_clk);
			n++;
		end
		if (reg_rvalid !== 1'b1) begin
			miscompares++;
			tally_and_finish();
		end else
			chk("read", reg_rdata, e);
	endtask
	// ****
	// Main sequence
	// ****
	initial begin
		repeat (2) @(negedge sys_clk);
		reset_n = 1;
		repeat (4) @(negedge sys_clk);
		rd(8'hff, 8'h00);
		wr(8'h02, 8'h5a);
		rd(8'h02, 8'h5a);
		for (int i = 0; i < 4; i++) begin
			wr(8'hff, 8'h04 + 8'(i));
			wr(8'h00, 8'(17 * i + 16));
		end
		chk("shared0", sh.mem[0], 8'h00);
		chk("refclk", {4'h0, refclk_domain_reset}, 8'h0c);
		chk("vco", {4'h0, vco_divider_domain_reset}, 8'h0a);
		for (int i = 0; i < 4; i++) begin
			wr(8'hff, 8'h0c + 8'(i));
			rd(8'h00, 8'(17 * i + 16));
		end
		wr(8'h00, 8'h08);
		chk("core", {4'h0, lane_core_reset}, 8'h0f);
		chk("refclk2", {4'h0, refclk_domain_reset}, 8'h00);
		wr(8'hff, 8'h00);
		rd(8'h02, 8'h5a);
		wr(8'h00, 8'h77);
		rd(8'h00, 8'h77);
		chk("core2", {4'h0, lane_core_reset}, 8'h0f);
		lock_in = 4'hd;
		signal_in = 4'hd;
		repeat (6) @(negedge sys_clk);
		wr(8'hff, 8'h05);
		rd(8'h01, 8'h11);
		rd(8'h01, 8'h01);
		wr(8'hff, 8'h04);
		rd(8'h01, 8'h00);
		wr(8'hff, 8'h05);
		rd(8'h02, 8'h00);
		wr(8'h01, 8'he0);
		rd(8'h01, 8'he1);
		wr(8'h00, 8'h04);
		rd(8'h00, 8'h00);
		rd(8'h01, 8'h00);
		chk("core3", {4'h0, lane_core_reset}, 8'h0d);
		tally_and_finish();
	end
endmodule
